/* File: sfpf_defines.vh */
// Purpose: constants for the serial flash pin front end
// Assumes: system clock of 25 MHz
// Notes:   lane mode codes, pin function and package codes, reset pulse timing
`ifndef SFPF_DEFINES_VH
`define SFPF_DEFINES_VH

`define SFPF_CLK_MHZ        25
`define SFPF_RESET_MIN_NS   1000
`define SFPF_RESET_CYCLES   ((`SFPF_RESET_MIN_NS * `SFPF_CLK_MHZ + 999) / 1000)

`define SFPF_MODE_SINGLE    2'h0
`define SFPF_MODE_DUAL      2'h1
`define SFPF_MODE_QUAD      2'h2

`define SFPF_PINFN_PAUSE    1'h0
`define SFPF_PINFN_RESET    1'h1

`define SFPF_PKG_8PIN       1'h0
`define SFPF_PKG_16PIN      1'h1

`define SFPF_SECTOR_BYTES   4096
`define SFPF_FIFO_DEPTH     4

`endif

/* File: sfpf_fifo.v */
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   depth must be a power of two
`timescale 1ns/100ps
module sfpf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_in,
    input  wire             nrst_in,
    input  wire             flush_in,
    input  wire [WIDTH-1:0] wr_data_in,
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire             rd_valid_out,
    input  wire             rd_ready_in
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            full;
    wire            empty;
    wire            do_wr;
    wire            do_rd;

    // full and empty from pointer comparison
    assign empty        = (wr_ptr == rd_ptr);
    assign full         = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign wr_ready_out = ~full;
    assign rd_valid_out = ~empty;
    assign rd_data_out  = mem[rd_ptr[AW-1:0]];
    assign do_wr        = wr_valid_in & ~full;
    assign do_rd        = rd_ready_in & ~empty;

    // storage array
    always @(posedge clk_in)
    begin
        if (do_wr)
            mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end

    // pointers
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else if (flush_in)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

/* File: sfpf_front_end.v */
// Purpose: pin-level front end of a serial flash: select, lanes, pause, reset
// Assumes: serial clock well below clk_in/4; all pins sampled by two flops
// Notes:   received bytes go to the core through a FIFO; send bytes come in
//          from the core; instruction decode lives outside this block
// Operation
// - deselected device floats every data lane
// - select low accepts input, allows output
// - ignore traffic until first select fall
// - single mode samples serial input on rise
// - single mode drives output on fall
// - dual/quad lanes bidirectional, rise in/fall out
// - quad traffic only when quad enable set
// - quad enable turns protect/pause pins into lanes
// - protect, pause, reset only in single/dual
// - protect pin low blocks status writes while protect bits set
// - block bits alone guard array, protect pin not used
// - pause floats output, ignores input and clock
// - pause release resumes where it stopped
// - 8-pin lane3 is pause or reset
// - 16-pin dedicated reset always works
// - pin-function bit: 0 pause, 1 reset
// - pause starts/ends with clock low
// - reset low aborts, blocks commands, power-on state
`timescale 1ns/100ps
`include "sfpf_defines.vh"
module sfpf_front_end #(
    parameter PACKAGE_16PIN = 1'b0,
    parameter FIFO_DEPTH    = `SFPF_FIFO_DEPTH,
    parameter FIFO_AW       = 2
) (
    input  wire       clk_in,
    input  wire       nrst_in,
    input  wire       cs_n_in,
    input  wire       sclk_in,
    input  wire       lane0_in,
    output wire       lane0_out,
    output wire       lane0_oe_n_out,
    input  wire       lane1_in,
    output wire       lane1_out,
    output wire       lane1_oe_n_out,
    input  wire       lane2_in,
    output wire       lane2_out,
    output wire       lane2_oe_n_out,
    input  wire       lane3_in,
    output wire       lane3_out,
    output wire       lane3_oe_n_out,
    input  wire       reset_pin_n_in,
    input  wire       quad_enable_in,
    input  wire       pin_function_in,
    input  wire [1:0] lane_mode_in,
    input  wire       drive_en_in,
    input  wire       status_protect_bits_in,
    input  wire       status_write_req_in,
    input  wire       array_write_req_in,
    input  wire [2:0] block_protect_in,
    input  wire       top_bottom_select_in,
    input  wire       sector_granularity_select_in,
    input  wire       protect_complement_in,
    input  wire [11:0] write_sector_in,
    input  wire [7:0] tx_data_in,
    input  wire       tx_valid_in,
    output wire       tx_ready_out,
    output wire [7:0] rx_data_out,
    output wire       rx_valid_out,
    input  wire       rx_ready_in,
    output reg        selected_out,
    output reg        paused_out,
    output reg        device_reset_out,
    output reg        status_write_ok_out,
    output reg        array_write_ok_out,
    output reg        overrun_out
);
    localparam [11:0] SECTORS = 12'hFFF;

    // two-flop synchronisers for every pin
    reg [6:0] sync_a;
    reg [6:0] sync_b;
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            // select resets low: a select already low at release is not a fall
            sync_a <= 7'h7C;
            sync_b <= 7'h7C;
        end
        else
        begin
            sync_a <= {reset_pin_n_in, lane3_in, lane2_in, lane1_in, lane0_in, sclk_in, cs_n_in};
            sync_b <= sync_a;
        end
    end
    wire cs_n    = sync_b[0];
    wire sclk    = sync_b[1];
    wire [3:0] lanes = sync_b[5:2];
    wire rst_pin_n = sync_b[6];

    // clock edge detect on synchronised samples
    reg sclk_d;
    reg cs_n_d;
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b0;
        end
        else
        begin
            sclk_d <= sclk;
            cs_n_d <= cs_n;
        end
    end
    wire sclk_rise = sclk & ~sclk_d;
    wire sclk_fall = ~sclk & sclk_d;
    wire cs_fall   = ~cs_n & cs_n_d;

    // effective mode: quad only with quad enable
    // quad gate
    wire [1:0] mode = (lane_mode_in == `SFPF_MODE_QUAD && !quad_enable_in) ?
                      `SFPF_MODE_SINGLE : lane_mode_in;

    // lane3/lane2 side functions, valid only without quad enable
    // pin roles
    wire lane3_pause_role = !quad_enable_in && (pin_function_in == `SFPF_PINFN_PAUSE);
    wire lane3_reset_role = !quad_enable_in && (pin_function_in == `SFPF_PINFN_RESET)
                            && (PACKAGE_16PIN == `SFPF_PKG_8PIN);
    wire pause_n = lane3_pause_role ? lanes[3] : 1'b1;
    wire protect_n = quad_enable_in ? 1'b1 : lanes[2];

    // reset sources
    // dedicated pin
    wire reset_req = ((PACKAGE_16PIN == `SFPF_PKG_16PIN) && !rst_pin_n) ||
                     (lane3_reset_role && !lanes[3]);

    localparam integer RST_CYC_I = `SFPF_RESET_CYCLES;
    localparam [7:0]   RST_CYC   = RST_CYC_I[7:0];
    reg [7:0] rst_cnt;
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rst_cnt          <= 8'h00;
            device_reset_out <= 1'b0;
        end
        else if (reset_req)
        begin
            if (rst_cnt != RST_CYC)
                rst_cnt <= rst_cnt + 8'h01;
            else
                device_reset_out <= 1'b1;
        end
        else
        begin
            rst_cnt          <= 8'h00;
            device_reset_out <= 1'b0;
        end
    end
    wire in_reset = reset_req;

    // armed after first select fall since power-on/reset
    // arm
    reg armed;
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            armed <= 1'b0;
        else if (device_reset_out)
            armed <= 1'b0;
        else if (cs_fall)
            armed <= 1'b1;
    end

    wire sel = armed && !cs_n && !in_reset;

    // pause state: follows the pause pin only while clock low
    // pause timing
    reg paused;
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            paused <= 1'b0;
        else if (!sel)
            paused <= 1'b0;
        else if (!lane3_pause_role)
            paused <= 1'b0;     // quad enable or reset role drops pause at once
        else if (!sclk)
            paused <= !pause_n;
    end

    // shift engine; frozen while paused so the transfer resumes
    // resume
    reg [7:0] rx_shift;
    reg [3:0] rx_cnt;
    reg [7:0] tx_shift;
    reg [3:0] tx_cnt;
    reg       tx_loaded;
    reg [3:0] out_bits;
    reg       rx_push;
    reg [7:0] rx_byte;
    reg       overrun;
    wire      rx_ready_w;
    wire [3:0] step = (mode == `SFPF_MODE_QUAD) ? 4'h4 :
                      (mode == `SFPF_MODE_DUAL) ? 4'h2 : 4'h1;
    wire active = sel && !paused;

    // pop the next send byte at a byte boundary on falling edge
    wire tx_take = active && drive_en_in && sclk_fall && (!tx_loaded || tx_cnt == 4'h0);
    assign tx_ready_out = tx_take;

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rx_shift  <= 8'h00;
            rx_cnt    <= 4'h0;
            rx_push   <= 1'b0;
            rx_byte   <= 8'h00;
            tx_shift  <= 8'h00;
            tx_cnt    <= 4'h0;
            tx_loaded <= 1'b0;
            out_bits  <= 4'h0;
            overrun   <= 1'b0;
        end
        else if (!sel)
        begin
            rx_cnt    <= 4'h0;
            tx_cnt    <= 4'h0;
            tx_loaded <= 1'b0;
            rx_push   <= 1'b0;
        end
        else
        begin
            rx_push <= 1'b0;
            if (active && sclk_rise && !drive_en_in)
            begin
                case (mode)
                    `SFPF_MODE_QUAD:
                    begin
                        rx_shift <= {rx_shift[3:0], lanes};
                    end
                    `SFPF_MODE_DUAL:
                    begin
                        rx_shift <= {rx_shift[5:0], lanes[1:0]};
                    end
                    default:
                    begin
                        rx_shift <= {rx_shift[6:0], lanes[0]};
                    end
                endcase
                if (rx_cnt + step >= 4'h8)
                begin
                    rx_cnt  <= 4'h0;
                    rx_push <= 1'b1;
                    case (mode)
                        `SFPF_MODE_QUAD: rx_byte <= {rx_shift[3:0], lanes};
                        `SFPF_MODE_DUAL: rx_byte <= {rx_shift[5:0], lanes[1:0]};
                        default:         rx_byte <= {rx_shift[6:0], lanes[0]};
                    endcase
                    if (!rx_ready_w)
                        overrun <= 1'b1;
                end
                else
                    rx_cnt <= rx_cnt + step;
            end
            if (active && drive_en_in && sclk_fall)
            begin
                if (tx_take)
                begin
                    tx_loaded <= tx_valid_in;
                    case (mode)
                        `SFPF_MODE_QUAD: out_bits <= tx_data_in[7:4];
                        `SFPF_MODE_DUAL: out_bits <= {2'h0, tx_data_in[7:6]};
                        default:         out_bits <= {3'h0, tx_data_in[7]};
                    endcase
                    tx_shift <= tx_data_in << step;
                    tx_cnt   <= 4'h8 - step;
                end
                else
                begin
                    case (mode)
                        `SFPF_MODE_QUAD: out_bits <= tx_shift[7:4];
                        `SFPF_MODE_DUAL: out_bits <= {2'h0, tx_shift[7:6]};
                        default:         out_bits <= {3'h0, tx_shift[7]};
                    endcase
                    tx_shift <= tx_shift << step;
                    tx_cnt   <= tx_cnt - step;
                end
            end
        end
    end

    // received byte buffer toward the core
    sfpf_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rx_fifo (
        .clk_in       (clk_in),
        .nrst_in      (nrst_in),
        .flush_in     (device_reset_out),
        .wr_data_in   (rx_byte),
        .wr_valid_in  (rx_push),
        .wr_ready_out (rx_ready_w),
        .rd_data_out  (rx_data_out),
        .rd_valid_out (rx_valid_out),
        .rd_ready_in  (rx_ready_in)
    );

    // output enables: low while driving, float when deselected or paused
    // lane float
    wire drv = active && drive_en_in;
    assign lane0_out      = out_bits[0] & (mode != `SFPF_MODE_SINGLE);
    assign lane0_oe_n_out = ~(drv && mode != `SFPF_MODE_SINGLE);
    assign lane1_out      = (mode == `SFPF_MODE_SINGLE) ? out_bits[0] : out_bits[1];
    assign lane1_oe_n_out = ~drv;
    assign lane2_out      = out_bits[2];
    assign lane2_oe_n_out = ~(drv && mode == `SFPF_MODE_QUAD);
    assign lane3_out      = out_bits[3];
    assign lane3_oe_n_out = ~(drv && mode == `SFPF_MODE_QUAD);

    // write protection of status and array
    // protect checks
    reg [11:0] span;
    reg        hit;
    always @*
    begin
        span = 12'h000;
        hit  = 1'b0;
        if (block_protect_in != 3'h0)
        begin
            if (sector_granularity_select_in)
                span = (12'h001 << (block_protect_in[1:0])) - 12'h001;
            else
                span = (12'h010 << block_protect_in) - 12'h001;
            if (block_protect_in == 3'h7 && !sector_granularity_select_in)
                span = SECTORS;
            if (top_bottom_select_in)
                hit = (write_sector_in <= span);
            else
                hit = (write_sector_in >= (SECTORS - span));
        end
        if (protect_complement_in)
            hit = ~hit;
    end

    // status flags toward the core
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            selected_out        <= 1'b0;
            paused_out          <= 1'b0;
            status_write_ok_out <= 1'b0;
            array_write_ok_out  <= 1'b0;
            overrun_out         <= 1'b0;
        end
        else
        begin
            selected_out        <= sel;
            paused_out          <= paused;
            status_write_ok_out <= status_write_req_in && sel &&
                                   !(status_protect_bits_in && !protect_n);
            array_write_ok_out  <= array_write_req_in && sel && !hit;
            overrun_out         <= overrun;
        end
    end
endmodule

/* File: sfpf_front_end_asserts.sv */
// Purpose: port-level checks of the serial flash pin front end
// Assumes: pins pass two sync flops, so causes are held a few cycles
// Notes:   dedicated reset checks apply to the 16-pin package only
`timescale 1ns/100ps
module sfpf_front_end_asserts #(
    parameter PACKAGE_16PIN = 1'b0
) (
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic       cs_n_in,
    input wire logic       lane2_in,
    input wire logic       reset_pin_n_in,
    input wire logic       quad_enable_in,
    input wire logic [1:0] lane_mode_in,
    input wire logic       status_protect_bits_in,
    input wire logic       lane0_oe_n_out,
    input wire logic       lane1_oe_n_out,
    input wire logic       lane2_oe_n_out,
    input wire logic       lane3_oe_n_out,
    input wire logic       paused_out,
    input wire logic       selected_out,
    input wire logic       device_reset_out,
    input wire logic       status_write_ok_out,
    input wire logic       overrun_out
);
    localparam int RST_CYC = 25;
    logic [5:0] rst_cnt;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // cycles the dedicated reset pin has been held low
    always_ff @(posedge clk_in or negedge nrst_in)
        if (!nrst_in)
            rst_cnt <= 6'h00;
        else if (reset_pin_n_in)
            rst_cnt <= 6'h00;
        else if (rst_cnt != 6'h3F)
            rst_cnt <= rst_cnt + 6'h01;
    // select held high long enough to pass the sync flops
    sequence s_desel;
        cs_n_in [*5];
    endsequence
    // upper lanes not in use as data
    sequence s_narrow;
        (lane_mode_in != 2'h2 || !quad_enable_in) [*4];
    endsequence
    a_desel_float: assert property (
        s_desel |-> &{lane0_oe_n_out, lane1_oe_n_out, lane2_oe_n_out, lane3_oe_n_out})
        else $error("lane driven while deselected");
    a_desel_idle: assert property (
        s_desel |-> !selected_out) else $error("selected while select high");
    a_upper_float: assert property (
        s_narrow |-> lane2_oe_n_out && lane3_oe_n_out) else $error("upper lane driven");
    a_single_in: assert property (
        (lane_mode_in == 2'h0) [*4] |-> lane0_oe_n_out) else $error("lane0 driven in single");
    a_pause_float: assert property (
        paused_out |-> $past(lane1_oe_n_out)) else $error("output driven while paused");
    a_quad_no_pause: assert property (
        quad_enable_in [*4] |-> !paused_out) else $error("pause with quad enable set");
    a_rst_min: assert property (
        PACKAGE_16PIN && $rose(device_reset_out) |-> rst_cnt >= RST_CYC)
        else $error("device reset after too short a pulse");
    a_rst_taken: assert property (
        PACKAGE_16PIN && rst_cnt == 6'h23 |-> device_reset_out) else $error("reset not taken");
    a_wp_blocks: assert property (
        (status_protect_bits_in && !lane2_in && !quad_enable_in) [*4] |-> !status_write_ok_out)
        else $error("status write allowed while protected");
    a_overrun_sticky: assert property (
        overrun_out |=> overrun_out) else $error("overrun flag cleared");
endmodule
bind sfpf_front_end sfpf_front_end_asserts #(.PACKAGE_16PIN(PACKAGE_16PIN)) i_chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in), .lane2_in(lane2_in),
    .reset_pin_n_in(reset_pin_n_in), .quad_enable_in(quad_enable_in),
    .lane_mode_in(lane_mode_in), .status_protect_bits_in(status_protect_bits_in),
    .lane0_oe_n_out(lane0_oe_n_out), .lane1_oe_n_out(lane1_oe_n_out),
    .lane2_oe_n_out(lane2_oe_n_out), .lane3_oe_n_out(lane3_oe_n_out),
    .paused_out(paused_out), .selected_out(selected_out),
    .device_reset_out(device_reset_out), .status_write_ok_out(status_write_ok_out),
    .overrun_out(overrun_out)
);

/* File: sfpf_host_model.sv */
// Purpose: behavioural serial host driving select, serial clock and lanes
// Assumes: clock idles high between frames, 320 ns period
// Notes:   data changes on the falling clock edge; read bits taken late in the high phase
`timescale 1ns/100ps
module sfpf_host_model (
    output logic       cs_n_out,
    output logic       sclk_out,
    output logic [3:0] drv_out,
    output logic [3:0] drv_en_out,
    input  wire logic [3:0] lanes_in
);
    // idle: deselected, clock high, lanes released
    initial
    begin
        {cs_n_out, sclk_out} = 2'h3;
        {drv_out, drv_en_out} = 8'h00;
    end
    // select falls before traffic, stays low through pause
    task sel();
        #37;
        cs_n_out = 1'b0;
        #160;
    endtask
    // release lanes, then deselect
    task desel();
        #160;
        drv_en_out = 4'h0;
        cs_n_out = 1'b1;
        #160;
    endtask
    // drive on fall, sample before next fall
    task tick(input logic [3:0] o, input logic [3:0] en, output logic [3:0] i);
        sclk_out = 1'b0;
        drv_out = o;
        drv_en_out = en;
        #160;
        sclk_out = 1'b1;
        #150;
        i = lanes_in;
        #10;
    endtask
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench for the serial flash pin front end
// Assumes: 16-pin package, host model with a 320 ns serial clock
// Notes:   written bytes are queued and matched as the buffer hands them out
`timescale 1ns/100ps
module testbench;
    logic        clk_in, nrst_in, flip, hold_n, wp_n, cs_n, sclk;
    logic [3:0]  h_drv, h_en;
    wire  [3:0]  lanes, l_out, l_oe_n;
    logic        reset_pin_n_in, quad_enable_in, pin_function_in, drive_en_in;
    logic        status_protect_bits_in, status_write_req_in, array_write_req_in;
    logic        top_bottom_select_in, sector_granularity_select_in, protect_complement_in;
    logic [1:0]  lane_mode_in;
    logic [2:0]  block_protect_in;
    logic [11:0] write_sector_in;
    logic [7:0]  tx_data_in, rx_data_out, q;
    logic        tx_valid_in, tx_ready_out, rx_valid_out, rx_ready_in, selected_out;
    logic        paused_out, device_reset_out, status_write_ok_out, array_write_ok_out;
    logic        overrun_out;
    logic [7:0]  exp_q[$];
    int          n_errors = 0, checks = 0, cyc = 0, n_take = 0;
    // 25 MHz system clock
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = !clk_in;
    end
    // released lanes: 2 and 3 follow wp_n and hold_n, 0 and 1 flip every cycle
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        assign lanes[g] = !l_oe_n[g] ? l_out[g] : h_en[g] ? h_drv[g] :
                          g == 2 ? wp_n : g == 3 ? hold_n : flip;
    end
    sfpf_front_end #(.PACKAGE_16PIN(1'b1)) i_dut (
        .clk_in, .nrst_in, .cs_n_in(cs_n), .sclk_in(sclk),
        .lane0_in(lanes[0]), .lane0_out(l_out[0]), .lane0_oe_n_out(l_oe_n[0]),
        .lane1_in(lanes[1]), .lane1_out(l_out[1]), .lane1_oe_n_out(l_oe_n[1]),
        .lane2_in(lanes[2]), .lane2_out(l_out[2]), .lane2_oe_n_out(l_oe_n[2]),
        .lane3_in(lanes[3]), .lane3_out(l_out[3]), .lane3_oe_n_out(l_oe_n[3]),
        .reset_pin_n_in, .quad_enable_in, .pin_function_in, .lane_mode_in, .drive_en_in,
        .status_protect_bits_in, .status_write_req_in, .array_write_req_in,
        .block_protect_in, .top_bottom_select_in, .sector_granularity_select_in,
        .protect_complement_in, .write_sector_in, .tx_data_in, .tx_valid_in,
        .tx_ready_out, .rx_data_out, .rx_valid_out, .rx_ready_in, .selected_out,
        .paused_out, .device_reset_out, .status_write_ok_out, .array_write_ok_out,
        .overrun_out
    );
    sfpf_host_model i_host (
        .cs_n_out(cs_n), .sclk_out(sclk), .drv_out(h_drv), .drv_en_out(h_en), .lanes_in(lanes)
    );
    task end_sim();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // flip toggle and hang limit
    always @(posedge clk_in)
    begin
        flip <= !flip;
        cyc++;
        if (tx_ready_out === 1'b1)
            n_take++;
        if (cyc == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end
    // oldest noted byte is compared whenever the buffer hands one out
    always @(posedge clk_in)
        if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1)
            cmp8(rx_data_out, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    // hold low while the clock is high, two ignored clocks, release
    task automatic pause_mid();
        logic [3:0] junk;
        @(negedge clk_in) hold_n = 1'b0;
        i_host.tick(4'h0, 4'h1, junk);
        i_host.tick(4'h1, 4'h1, junk);
        cmp8(paused_out, 1'b1);
        cmp8(l_oe_n[1], 1'b1);
        @(negedge clk_in) hold_n = 1'b1;
    endtask
    // one byte, w lanes wide, most significant first; optional pause before unit pz
    task automatic xfer(input int w, input logic [7:0] d, input int pz, output logic [7:0] r);
        logic [3:0] i;
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        r = 8'h00;
        for (int k = 0; k < 8 / w; k++)
        begin
            if (k == pz)
                pause_mid();
            i_host.tick(4'(d >> (8 - w * (k + 1))) & m, drive_en_in ? 4'h0 : m, i);
            r = (r << w) | 8'(w == 1 ? i[1] : i & m);
        end
    endtask
    task automatic wr(input int w, input logic [7:0] d, input int pz);
        exp_q.push_back(d);
        xfer(w, d, pz, q);
    endtask
    task automatic rd(input int w, input logic [7:0] d);
        @(negedge clk_in);
        {drive_en_in, tx_valid_in, tx_data_in} = {2'h3, d};
        n_take = 0;
        xfer(w, 8'h00, -1, q);
        @(negedge clk_in);
        {drive_en_in, tx_valid_in} = 2'h0;
        cmp8(q, d);
        cmp8(8'(n_take), 8'h01);
    endtask
    // main sequence
    initial
    begin
        {nrst_in, flip, hold_n, wp_n, reset_pin_n_in, rx_ready_in} = 6'h0F;
        {quad_enable_in, pin_function_in, drive_en_in, tx_valid_in} = 4'h0;
        {status_protect_bits_in, status_write_req_in, array_write_req_in} = 3'h0;
        {lane_mode_in, block_protect_in, tx_data_in} = 13'h0000;
        void'($urandom(96));
        {top_bottom_select_in, sector_granularity_select_in, protect_complement_in} = 3'($urandom);
        write_sector_in = 12'($urandom);
        i_host.sel();
        repeat (8) @(posedge clk_in);
        @(negedge clk_in) nrst_in = 1'b1;
        xfer(1, 8'h3C, -1, q);
        i_host.desel();
        i_host.sel();
        wr(1, 8'hA5, 4);
        @(negedge clk_in) lane_mode_in = 2'h2;
        wr(1, 8'($urandom), -1);
        i_host.desel();
        for (int m = 0; m < 3; m++)
        begin
            @(negedge clk_in);
            {lane_mode_in, quad_enable_in} = {2'(m), 1'b1};
            i_host.sel();
            cmp8(selected_out, 1'b1);
            wr(1 << m, 8'($urandom), -1);
            rd(1 << m, 8'($urandom));
            i_host.desel();
        end
        @(negedge clk_in) {rx_ready_in, lane_mode_in, quad_enable_in} = 4'h0;
        i_host.sel();
        for (int k = 0; k < 5; k++)
            if (k < 4)
                wr(1, 8'($urandom), -1);
            else
                xfer(1, 8'($urandom), -1, q);
        i_host.desel();
        cmp8(overrun_out, 1'b1);
        @(negedge clk_in) rx_ready_in = 1'b1;
        repeat (12) @(negedge clk_in);
        cmp8(rx_valid_out, 1'b0);
        i_host.sel();
        for (int c = 0; c < 8; c++)
        begin
            @(negedge clk_in);
            {status_protect_bits_in, wp_n, quad_enable_in} = 3'(c);
            {status_write_req_in, array_write_req_in} = 2'h3;
            repeat (6) @(negedge clk_in);
            cmp8(status_write_ok_out, !(c[2] && !c[1] && !c[0]));
            cmp8(array_write_ok_out, !protect_complement_in);
        end
        i_host.desel();
        @(negedge clk_in) {pin_function_in, reset_pin_n_in} = 2'h2;
        repeat (10) @(negedge clk_in);
        cmp8(device_reset_out, 1'b0);
        repeat (30) @(negedge clk_in);
        cmp8(device_reset_out, 1'b1);
        reset_pin_n_in = 1'b1;
        repeat (8) @(negedge clk_in);
        end_sim();
    end
endmodule
